// [src/dp_ram_defs.vh]
// Register offsets, field positions, reset values and scheme codes of the two-port RAM
`ifndef DP_RAM_DEFS_VH
`define DP_RAM_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RAM_CTRL_OFS 4'h0
`define RAM_STATUS_OFS 4'h4
`define RAM_SHAPE_OFS 4'h8

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define RAM_CTRL_SCHEME_LSB 0
`define RAM_CTRL_SCHEME_MSB 1
`define RAM_CTRL_RDSTB_BIT 2
`define RAM_CTRL_MASK_BIT 3
`define RAM_CTRL_RESET 4'h0

// ----------------------------------------------------------------
// Clocking schemes
// ----------------------------------------------------------------
`define RAM_SCHEME_SINGLE 2'h0
`define RAM_SCHEME_WR_RD 2'h1
`define RAM_SCHEME_IN_OUT 2'h2

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// [src/two_port_embedded_ram.v]
// Simple dual-port embedded RAM with clocking schemes, strobes, lane mask and AXI4-Lite control
//
// Contract
// - Single scheme: one clock drives both sides; all registered ports share it.
// - Write/read scheme: write word, location, strobe and mask taken on write clock.
// - Write/read scheme: read location, read strobe and read data on read clock.
// - Input/output scheme: all registered inputs sampled on the input clock.
// - Input/output scheme: read data updates only on the output clock.
// - Optional read strobe qualifies read location; only without block-memory selection.
// - Lane mask writes only selected lanes; unselected stored positions stay unchanged.
// - No lane mask when built from logic cells or read-only topology.
// - Output clock gate low: output-side registers hold.
// - Input clock gate low: input-side registers hold.
// - Read data is mandatory and exactly as wide as the write word.
// - Port A write word required in one-port, simple and two-way topologies.
// - Port A location is always required.
// - Port A write strobe qualifies writes at the port A location.
// - Write and read locations have identical widths.
`timescale 1ns/1ps
`default_nettype none
`include "dp_ram_defs.vh"

module two_port_embedded_ram #(
    parameter DATA_W = 32,
    parameter ADDR_W = 8,
    parameter MASK_W = 4,
    parameter USE_BLOCK_MEM = 0,
    parameter IMPL_IN_LES = 0,
    parameter READ_ONLY = 0
) (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_b,
    // Side ticks and clock gates
    input wire i_in_tick,
    input wire i_out_tick,
    input wire i_in_clk_gate,
    input wire i_out_clk_gate,
    // Write port (port A)
    input wire [DATA_W-1:0] i_wr_word,
    input wire [ADDR_W-1:0] i_wr_addr,
    input wire i_wr_stb,
    input wire [MASK_W-1:0] i_lane_mask,
    // Read port
    input wire [ADDR_W-1:0] i_rd_addr,
    input wire i_rd_stb,
    output reg [DATA_W-1:0] o_rd_word,
    // AXI4-Lite write address and data
    input wire [3:0] i_awaddr,
    input wire i_awvalid,
    output reg o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output reg o_wready,
    // AXI4-Lite write response
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    // AXI4-Lite read
    input wire [3:0] i_araddr,
    input wire i_arvalid,
    output reg o_arready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready
);

    localparam LANE_W = DATA_W / MASK_W;
    localparam DEPTH = 1 << ADDR_W;
    // Mask is only offered when not built from logic cells and writable, whatever USE_BLOCK_MEM is
    localparam MASK_OK = (IMPL_IN_LES == 0) && (READ_ONLY == 0);
    localparam RDSTB_OK = (USE_BLOCK_MEM == 0);

    // ----------------------------------------------------------------
    // Storage and side state
    // ----------------------------------------------------------------
    reg [DATA_W-1:0] mem [0:DEPTH-1];
    reg [3:0] ctrl_reg;
    reg [ADDR_W-1:0] rd_addr_reg;
    reg rd_stb_reg;
    reg [15:0] wr_count_reg;
    reg [15:0] rd_count_reg;

    wire [1:0] scheme = ctrl_reg[`RAM_CTRL_SCHEME_MSB:`RAM_CTRL_SCHEME_LSB];
    wire use_rd_stb = ctrl_reg[`RAM_CTRL_RDSTB_BIT];
    wire use_mask = ctrl_reg[`RAM_CTRL_MASK_BIT];

    // ----------------------------------------------------------------
    // Side edge selection
    // ----------------------------------------------------------------
    // Input gate holds
    wire in_edge = i_in_tick & i_in_clk_gate;
    wire out_src = (scheme == `RAM_SCHEME_SINGLE) ? i_in_tick : i_out_tick;
    wire out_edge = out_src & i_out_clk_gate;
    wire rd_addr_edge = (scheme == `RAM_SCHEME_WR_RD) ? out_edge : in_edge;

    // ----------------------------------------------------------------
    // Write side
    // ----------------------------------------------------------------
    reg [DATA_W-1:0] merged_word;
    integer lane;
    always @* begin
        merged_word = mem[i_wr_addr];
        for (lane = 0; lane < MASK_W; lane = lane + 1) begin
            if (!(MASK_OK && use_mask) || i_lane_mask[lane]) begin
                merged_word[lane*LANE_W +: LANE_W] = i_wr_word[lane*LANE_W +: LANE_W];
            end
        end
    end

    always @(posedge i_ref_clk) begin
        if (in_edge && i_wr_stb && (READ_ONLY == 0)) begin
            mem[i_wr_addr] <= merged_word;
        end
    end

    // ----------------------------------------------------------------
    // Read side
    // ----------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            rd_addr_reg <= {ADDR_W{1'b0}};
            rd_stb_reg <= 1'b0;
            o_rd_word <= {DATA_W{1'b0}};
            rd_count_reg <= 16'h0000;
        end else begin
            if (rd_addr_edge) begin
                rd_addr_reg <= i_rd_addr;
                rd_stb_reg <= (RDSTB_OK && use_rd_stb) ? i_rd_stb : 1'b1;
            end
            if (out_edge) begin
                if (rd_stb_reg) begin
                    o_rd_word <= mem[rd_addr_reg];
                    rd_count_reg <= rd_count_reg + 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Write activity counter
    // ----------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            wr_count_reg <= 16'h0000;
        end else if (in_edge && i_wr_stb && (READ_ONLY == 0)) begin
            wr_count_reg <= wr_count_reg + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    reg aw_held_reg;
    reg w_held_reg;
    reg [3:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    wire aw_take = i_awvalid & o_awready;
    wire w_take = i_wvalid & o_wready;
    wire aw_have = aw_held_reg | aw_take;
    wire w_have = w_held_reg | w_take;
    wire [3:0] wa = aw_take ? i_awaddr : aw_addr_reg;
    wire [31:0] wd = w_take ? i_wdata : w_data_reg;
    wire [3:0] ws = w_take ? i_wstrb : w_strb_reg;
    wire wr_fire = aw_have & w_have & ~o_bvalid;

    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= `AXI_RESP_OKAY;
            ctrl_reg <= `RAM_CTRL_RESET;
        end else begin
            if (aw_take) begin
                aw_addr_reg <= i_awaddr;
                aw_held_reg <= 1'b1;
                o_awready <= 1'b0;
            end
            if (w_take) begin
                w_data_reg <= i_wdata;
                w_strb_reg <= i_wstrb;
                w_held_reg <= 1'b1;
                o_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                o_bvalid <= 1'b1;
                if (wa == `RAM_CTRL_OFS) begin
                    o_bresp <= `AXI_RESP_OKAY;
                    if (ws[0]) begin
                        ctrl_reg <= wd[3:0];
                    end
                end else begin
                    o_bresp <= `AXI_RESP_SLVERR;
                end
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    reg [31:0] rd_mux;
    reg rd_hit;
    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (i_araddr)
            `RAM_CTRL_OFS: rd_mux = {28'h0000000, ctrl_reg};
            `RAM_STATUS_OFS: rd_mux = {rd_count_reg, wr_count_reg};
            `RAM_SHAPE_OFS: rd_mux = {8'h00, MASK_OK[0], RDSTB_OK[0], 6'h00,
                                      MASK_W[7:0], ADDR_W[7:0]};
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h00000000;
            o_rresp <= `AXI_RESP_OKAY;
        end else begin
            if (i_arvalid && o_arready) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= rd_mux;
                o_rresp <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end
            if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end

    // Port A in true dual-port maps onto the write port here:
    // Write word always present
    // Write strobe is a mandatory input

endmodule // two_port_embedded_ram
`default_nettype wire

// [verification/ram_port_checker_assertions.sv]
// Concurrent checks on the ports of the two-port RAM
`timescale 1ns/1ps
`default_nettype none
`include "dp_ram_defs.vh"
module ram_port_checker #(
    parameter DATA_W = 32
) (
    // Clock, ticks and gates
    input wire logic i_ref_clk, i_rst_b, i_in_tick, i_out_tick, i_out_clk_gate,
    // Read data
    input wire logic [DATA_W-1:0] o_rd_word,
    // AXI4-Lite
    input wire logic [3:0] i_awaddr, i_araddr,
    input wire logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready,
    input wire logic i_arvalid, o_arready, o_rvalid, i_rready,
    input wire logic [1:0] o_bresp, o_rresp,
    input wire logic [31:0] o_rdata
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_both;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    property p_out_gate;
        !i_out_clk_gate |=> $stable(o_rd_word);
    endproperty
    a_out_gate: assert property (p_out_gate)
        else $error("read data moved while output gate low");
    property p_no_tick;
        !i_in_tick && !i_out_tick |=> $stable(o_rd_word);
    endproperty
    a_no_tick: assert property (p_no_tick)
        else $error("read data moved without a clock tick");
    property p_b_after;
        s_both |=> o_bvalid && !o_awready && !o_wready;
    endproperty
    a_b_after: assert property (p_b_after)
        else $error("write response not raised after address and data");
    property p_b_hold;
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped before bready");
    property p_r_after;
        i_arvalid && o_arready |=> o_rvalid && !o_arready;
    endproperty
    a_r_after: assert property (p_r_after)
        else $error("read response not raised after address");
    property p_r_hold;
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read response changed before rready");
    property p_rd_unmapped;
        i_arvalid && o_arready && i_araddr == 4'hc |=> o_rresp == `AXI_RESP_SLVERR && o_rdata == 32'h0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not refused");
    property p_wr_ro;
        i_awaddr == 4'h4 ##0 s_both |=> o_bresp == `AXI_RESP_SLVERR;
    endproperty
    a_wr_ro: assert property (p_wr_ro)
        else $error("write to status not refused");
endmodule // ram_port_checker
bind two_port_embedded_ram ram_port_checker #(.DATA_W(DATA_W)) i_ram_port_checker (.*);
`default_nettype wire

// [verification/ram_user_clocks.sv]
// Tick source standing in for the user's write and read clocks
`timescale 1ns/1ps
`default_nettype none
module ram_user_clocks (
    // Clock and pace
    input wire logic i_ref_clk,
    input wire logic i_slow,
    // Side ticks
    output logic o_in_tick,
    output logic o_out_tick
);
    logic phase_reg = 1'b0;
    always @(posedge i_ref_clk) begin
        phase_reg <= ~phase_reg;
    end
    assign o_in_tick = i_slow ? phase_reg : 1'b1;
    assign o_out_tick = i_slow ? ~phase_reg : 1'b1;
endmodule // ram_user_clocks
`default_nettype wire

// [verification/two_port_embedded_ram_test.sv]
// Self-checking bench for the two-port RAM
`timescale 1ns/1ps
`default_nettype none
`include "dp_ram_defs.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module two_port_embedded_ram_test;
    logic i_ref_clk = 0, i_rst_b = 0, slow = 0, i_in_clk_gate = 1, i_out_clk_gate = 1;
    logic i_wr_stb = 0, i_rd_stb = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
    logic i_arvalid = 0, i_rready = 0, aw_hs, w_hs, b_hs, ar_hs, r_hs;
    logic i_in_tick, i_out_tick, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [31:0] i_wr_word = 0, i_wdata = 0, o_rd_word, o_rdata, v, w;
    logic [7:0] i_wr_addr = 0, i_rd_addr = 0, a;
    logic [3:0] i_lane_mask = 4'hf, i_awaddr = 0, i_araddr = 0, i_wstrb = 4'hf;
    logic [1:0] o_bresp, o_rresp, bq;
    logic [33:0] rq, obs, e, exp_q[$];
    int err_count = 0, comparisons = 0, cycles = 0;
    event got;
    ram_user_clocks i_ram_user_clocks (.i_ref_clk(i_ref_clk), .i_slow(slow),
        .o_in_tick(i_in_tick), .o_out_tick(i_out_tick));
    two_port_embedded_ram i_two_port_embedded_ram (.*);
    initial begin
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        aw_hs <= i_awvalid && o_awready;
        w_hs <= i_wvalid && o_wready;
        b_hs <= o_bvalid && i_bready;
        ar_hs <= i_arvalid && o_arready;
        r_hs <= o_rvalid && i_rready;
        bq <= o_bresp;
        rq <= {o_rresp, o_rdata};
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    always @(got) begin
        e = exp_q.pop_front();
        `CHK(obs, e)
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task note(input logic [33:0] x, input logic [33:0] o);
        exp_q.push_back(x);
        obs = o;
        ->got;
        #1;
    endtask
    task step;
        @(posedge i_ref_clk);
        #1;
    endtask
    task axi_wr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] r);
        logic ap, wp;
        begin
            i_awaddr <= ad; i_wdata <= d; i_awvalid <= 1; i_wvalid <= 1;
            ap = 1;
            wp = 1;
            while (ap || wp) begin
                step();
                if (aw_hs) begin i_awvalid <= 0; ap = 0; end
                if (w_hs) begin i_wvalid <= 0; wp = 0; end
            end
            step();
            i_bready <= 1;
            do step(); while (!b_hs);
            i_bready <= 0;
            note({r, 32'h0}, {bq, 32'h0});
        end
    endtask
    task axi_rd(input logic [3:0] ad, input logic [33:0] x);
        i_araddr <= ad;
        i_arvalid <= 1;
        do step(); while (!ar_hs);
        i_arvalid <= 0;
        step();
        i_rready <= 1;
        do step(); while (!r_hs);
        i_rready <= 0;
        note(x, rq);
    endtask
    task mem_wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] m);
        i_wr_addr <= ad; i_wr_word <= d; i_lane_mask <= m; i_wr_stb <= 1;
        repeat (4) step();
        i_wr_stb <= 0;
    endtask
    task mem_rd(input logic [7:0] ad, input logic s, input logic [31:0] x);
        i_rd_addr <= ad;
        i_rd_stb <= s;
        repeat (8) step();
        note({2'h0, x}, {2'h0, o_rd_word});
    endtask
    task complete_run;
        $display("errors %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        v = 32'h00010519;
        repeat (20) @(posedge i_ref_clk);
        i_rst_b <= 1;
        step();
        axi_rd(4'h0, 34'h0);
        axi_rd(4'hc, {`AXI_RESP_SLVERR, 32'h0});
        axi_rd(4'h8, {`AXI_RESP_OKAY, 32'h00c00408});
        axi_wr(4'h4, 32'h1, `AXI_RESP_SLVERR);
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 2; k++) begin
                slow <= k[0];
                axi_wr(4'h0, 32'h8 | s, `AXI_RESP_OKAY);
                v = lfsr(v);
                a = v[7:0];
                v = lfsr(v);
                w = v;
                mem_wr(a, w, 4'hf);
                mem_rd(a, 1, w);
                mem_wr(a, ~w, 4'h5);
                mem_rd(a, 1, (~w & 32'h00ff00ff) | (w & 32'hff00ff00));
            end
        end
        axi_wr(4'h0, 32'h0, `AXI_RESP_OKAY);
        mem_wr(a, w, 4'h1);
        mem_rd(a, 1, w);
        i_in_clk_gate <= 0;
        mem_wr(a, ~w, 4'hf);
        i_in_clk_gate <= 1;
        mem_rd(a, 1, w);
        i_out_clk_gate <= 0;
        mem_rd(a + 8'h1, 1, w);
        i_out_clk_gate <= 1;
        axi_wr(4'h0, 32'h4, `AXI_RESP_OKAY);
        axi_rd(4'h0, {`AXI_RESP_OKAY, 32'h4});
        mem_rd(a, 1, w);
        mem_rd(a + 8'h1, 0, w);
        complete_run();
    end
endmodule // two_port_embedded_ram_test
`default_nettype wire
